// file: core/dma_seq_pkg.sv
// Contract
// - single-address: read/write line high memory-to-device, low device-to-memory
// - dual-address: reads use source pointer and code, writes destination's
// - each pointer independently increments, decrements or stays after an operand
// - single-address needs operand size equal to port width; device pointer unused
// - single-address memory pointer steps one for bytes, two for words
// - dual-address operand takes two to six bus cycles
// - narrow source or destination splits an operand into two or four cycles
// - 16-bit device, byte operands, internal requests: two bytes per word cycle; here only with both pointers even, counting up, count above one
// - 8-bit device pointer steps two, four, eight; alternate byte addresses
// - fixed 8-bit device pointer still walks alternate bytes within an operand
// - internal requests double the dual-address step and use word cycles; here only for packed byte pairs
// - an aborted operand updates no address register
// - bus error discards held source data; restart retries from the read
// - transfer counter decrements only after all cycles of an operand succeed
// - internal requests with dual-address keep the acknowledge output inactive
// - request method from operation control; subtypes and rate timing elsewhere
// - auto-start raises the first request internally, later ones external
// - maximum rate keeps a request pending until the count is exhausted
// - limited rate counts clocks with bus grant acknowledge asserted per period
// - tally below burst time enables requests in the burst part of next period
// - bandwidth share set by ratio of sample period to burst time
// - burst 16/32/64/128 clocks; period burst times 2/4/8/16, up to 2048
package dma_seq_pkg;
	localparam logic [7:0] OFS_OPER = 8'h00;
	localparam logic [7:0] OFS_SEQ = 8'h04;
	localparam logic [7:0] OFS_DEVC = 8'h08;
	localparam logic [7:0] OFS_GEN = 8'h0C;
	localparam logic [7:0] OFS_MPTR = 8'h10;
	localparam logic [7:0] OFS_DPTR = 8'h14;
	localparam logic [7:0] OFS_CODES = 8'h18;
	localparam logic [7:0] OFS_COUNT = 8'h1C;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam int OCR_DIR = 0;
	localparam int OCR_SIZE_LO = 1;
	localparam int OCR_REQ_LO = 3;
	localparam int OCR_SINGLE = 5;
	localparam int SCR_MEM_LO = 0;
	localparam int SCR_DEV_LO = 2;
	localparam int DCR_PORT16 = 0;
	localparam int DCR_EXT_LO = 1;
	localparam int GCR_BT_LO = 0;
	localparam int GCR_BR_LO = 2;
	localparam int CODES_MEM_LO = 0;
	localparam int CODES_DEV_LO = 4;
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int STAT_ACTIVE = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ERR = 2;
	localparam int STAT_CFG = 3;
	localparam int STAT_PEND = 4;
	localparam int STAT_WIN = 5;
	localparam logic [2:0] OP_BYTE = 3'h1;
	localparam logic [2:0] OP_WORD = 3'h2;
	localparam logic [2:0] OP_LONG = 3'h4;
	localparam logic [11:0] BURST_BASE = 12'h010;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_RSVD = 2'h3
	} size_t;
	typedef enum logic [1:0] {
		REQ_MAX = 2'h0, REQ_LIMITED = 2'h1, REQ_EXT = 2'h2, REQ_AUTO = 2'h3
	} req_t;
	typedef enum logic [1:0] {
		CNT_FIXED = 2'h0, CNT_INC = 2'h1, CNT_DEC = 2'h2, CNT_RSVD = 2'h3
	} count_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, ST_WAIT = 5'h02, ST_RD = 5'h04, ST_WR = 5'h08,
		ST_SGL = 5'h10
	} state_t;
endpackage

// file: core/ptr_stepper.sv
`timescale 1ns/1ps
module ptr_stepper #(
	parameter int W = 24
) (
	input wire logic [W-1:0] ptr,
	input wire logic [1:0] mode,
	input wire logic [3:0] step,
	output logic [W-1:0] nxt
);
	always_comb begin
		case (mode)
			dma_seq_pkg::CNT_INC: nxt = ptr + W'(step);
			dma_seq_pkg::CNT_DEC: nxt = ptr - W'(step);
			default: nxt = ptr;
		endcase
	end
endmodule

// file: core/rate_window.sv
`timescale 1ns/1ps
module rate_window (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic busy,
	input wire logic [1:0] burst_sel,
	input wire logic [1:0] ratio_sel,
	output logic window
);
	logic [11:0] burst, period, cnt_q, cnt_d, tally_q;
	logic last, allow_q, allow_d;

	assign burst = dma_seq_pkg::BURST_BASE << burst_sel;
	// period over burst is the bandwidth ratio
	assign period = burst << ({1'b0, ratio_sel} + 3'h1);
	// >= guards a period shortened while the count is beyond it
	assign last = cnt_q >= period - 12'h001;
	assign cnt_d = last ? 12'h000 : cnt_q + 12'h001;
	assign allow_d = last ? ((tally_q + {11'h000, busy}) < burst) : allow_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 12'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tally_q <= 12'h000;
		end else if (last) begin
			tally_q <= 12'h000;
		end else begin
			tally_q <= tally_q + {11'h000, busy};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			allow_q <= 1'b0;
			window <= 1'b0;
		end else begin
			allow_q <= allow_d;
			window <= allow_d && (cnt_d < burst);
		end
	end

	sequence s_boundary;
		last;
	endsequence

	tally_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_boundary |=> tally_q == 12'h000 && cnt_q == 12'h000)
		else $error("tally not cleared at period boundary");
	window_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		window |-> allow_q && cnt_q < burst)
		else $error("request window outside burst time");
endmodule

// file: core/dma_channel_transfer_sequencer.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module dma_channel_transfer_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic bus_req,
	output logic [23:0] bus_addr,
	output logic [2:0] bus_fc,
	output logic bus_rw,
	output logic bus_word,
	output logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	input wire logic bus_done,
	input wire logic bus_err,
	output logic ack_n,
	input wire logic bgack_n,
	input wire logic ext_req_n
);
	logic [5:0] operation_control_reg;
	logic [3:0] sequence_control_reg;
	logic [2:0] device_control_reg;
	logic [3:0] general_control_reg;
	logic [23:0] memory_address_pointer, device_address_pointer;
	logic [2:0] memory_space_code, device_space_code;
	logic [15:0] memory_transfer_counter;
	dma_seq_pkg::state_t state_q;
	logic [2:0] part_q, cyc_cnt_q;
	logic [31:0] hold_q;
	logic pack_q, first_req_q, stop_q, done_q, err_q, cfg_err_q;
	logic [1:0] bg_s_q, ext_s_q;
	logic setup, wr_en, hit, active, start, stop_req, cfg_bad;
	logic dir_m2d, single, port16, internal, window, req_pend, pack_d;
	logic [1:0] memory_pointer_count_mode, dev_mode;
	dma_seq_pkg::size_t size;
	dma_seq_pkg::req_t req;
	logic [2:0] eb, rd_parts, wr_parts, rem;
	logic mem_w2, dev_w2, src_w2, dst_w2, cyc_mem, cyc_w2, cyc_ack;
	logic [23:0] cyc_addr, mptr_nxt, dptr_nxt;
	logic [6:0] sh;
	logic [31:0] shifted, rd_val;
	logic [15:0] cyc_wdata, dec, count_left;
	logic [3:0] mem_step, dev_step;
	logic cyc_end, op_complete, last_rd, last_wr;

	assign active = state_q != dma_seq_pkg::ST_IDLE;
	assign dir_m2d = operation_control_reg[dma_seq_pkg::OCR_DIR];
	assign single = operation_control_reg[dma_seq_pkg::OCR_SINGLE];
	assign size = dma_seq_pkg::size_t'(
		operation_control_reg[dma_seq_pkg::OCR_SIZE_LO +: 2]);
	assign req = dma_seq_pkg::req_t'(
		operation_control_reg[dma_seq_pkg::OCR_REQ_LO +: 2]);
	assign port16 = device_control_reg[dma_seq_pkg::DCR_PORT16];
	assign memory_pointer_count_mode =
		sequence_control_reg[dma_seq_pkg::SCR_MEM_LO +: 2];
	assign dev_mode = sequence_control_reg[dma_seq_pkg::SCR_DEV_LO +: 2];
	assign internal = req == dma_seq_pkg::REQ_MAX ||
		req == dma_seq_pkg::REQ_LIMITED;

	// pins from other masters: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bg_s_q <= 2'h3;
			ext_s_q <= 2'h3;
		end else begin
			bg_s_q <= {bg_s_q[0], bgack_n};
			ext_s_q <= {ext_s_q[0], ext_req_n};
		end
	end

	rate_window u_rate (
		.pclk(pclk),
		.presetn(presetn),
		.busy(!bg_s_q[1]),
		.burst_sel(general_control_reg[dma_seq_pkg::GCR_BT_LO +: 2]),
		.ratio_sel(general_control_reg[dma_seq_pkg::GCR_BR_LO +: 2]),
		.window(window)
	);

	always_comb begin
		case (req)
			dma_seq_pkg::REQ_MAX: req_pend = 1'b1;
			dma_seq_pkg::REQ_LIMITED: req_pend = window;
			dma_seq_pkg::REQ_AUTO: req_pend = first_req_q || !ext_s_q[1];
			default: req_pend = !ext_s_q[1];
		endcase
		if (memory_transfer_counter == 16'h0000) begin
			req_pend = 1'b0;
		end
	end

	// operand bytes; a packed pair of bytes moves as one word
	always_comb begin
		case (size)
			dma_seq_pkg::SZ_BYTE: eb = pack_q ? dma_seq_pkg::OP_WORD :
				dma_seq_pkg::OP_BYTE;
			dma_seq_pkg::SZ_WORD: eb = dma_seq_pkg::OP_WORD;
			dma_seq_pkg::SZ_LONG: eb = dma_seq_pkg::OP_LONG;
			default: eb = dma_seq_pkg::OP_BYTE;
		endcase
	end

	assign mem_w2 = eb != dma_seq_pkg::OP_BYTE;
	assign dev_w2 = port16 && mem_w2;
	assign src_w2 = dir_m2d ? mem_w2 : dev_w2;
	assign dst_w2 = dir_m2d ? dev_w2 : mem_w2;
	assign rd_parts = src_w2 ? {1'b0, eb[2:1]} : eb;
	assign wr_parts = dst_w2 ? {1'b0, eb[2:1]} : eb;
	assign last_rd = part_q == rd_parts - 3'h1;
	assign last_wr = part_q == wr_parts - 3'h1;
	assign pack_d = !single && size == dma_seq_pkg::SZ_BYTE && port16 &&
		internal && memory_transfer_counter > 16'h0001 &&
		!memory_address_pointer[0] && !device_address_pointer[0] &&
		memory_pointer_count_mode == dma_seq_pkg::CNT_INC &&
		dev_mode == dma_seq_pkg::CNT_INC;
	assign cfg_bad = size == dma_seq_pkg::SZ_RSVD || (single &&
		(size == dma_seq_pkg::SZ_LONG ||
		(size == dma_seq_pkg::SZ_WORD) != port16));

	always_comb begin
		case (state_q)
			dma_seq_pkg::ST_SGL: begin
				cyc_mem = 1'b1;
				cyc_w2 = size == dma_seq_pkg::SZ_WORD;
			end
			dma_seq_pkg::ST_RD: begin
				cyc_mem = dir_m2d;
				cyc_w2 = src_w2;
			end
			default: begin
				cyc_mem = !dir_m2d;
				cyc_w2 = dst_w2;
			end
		endcase
	end

	// parts of an operand sit two bytes apart on either port
	assign cyc_addr = (cyc_mem ? memory_address_pointer :
		device_address_pointer) + {20'h00000, part_q, 1'b0};
	assign rem = wr_parts - 3'h1 - part_q;
	assign sh = dst_w2 ? {rem, 4'h0} : {1'b0, rem, 3'h0};
	assign shifted = hold_q >> sh;
	assign cyc_wdata = dst_w2 ? shifted[15:0] : {8'h00, shifted[7:0]};
	assign cyc_ack = single || (!cyc_mem && !internal);

	assign cyc_end = bus_req && (bus_done || bus_err);
	assign op_complete = bus_req && bus_done && !bus_err &&
		(state_q == dma_seq_pkg::ST_SGL ||
		(state_q == dma_seq_pkg::ST_WR && last_wr));
	assign dec = {15'h0000, pack_q} + 16'h0001;
	assign count_left = memory_transfer_counter - dec;
	assign mem_step = {1'b0, eb};
	assign dev_step = port16 ? {1'b0, eb} : {eb, 1'b0};

	ptr_stepper #(.W(24)) u_mstep (
		.ptr(memory_address_pointer),
		.mode(memory_pointer_count_mode),
		.step(mem_step),
		.nxt(mptr_nxt)
	);

	ptr_stepper #(.W(24)) u_dstep (
		.ptr(device_address_pointer),
		.mode(dev_mode),
		.step(dev_step),
		.nxt(dptr_nxt)
	);

	// APB: no wait states, read data registered in the setup cycle
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;
	assign start = wr_en && paddr == dma_seq_pkg::OFS_CTRL && !active &&
		pwdata[dma_seq_pkg::CTRL_START];
	assign stop_req = wr_en && paddr == dma_seq_pkg::OFS_CTRL && active &&
		pwdata[dma_seq_pkg::CTRL_STOP];

	always_comb begin
		rd_val = 32'h00000000;
		hit = 1'b1;
		case (paddr)
			dma_seq_pkg::OFS_OPER: rd_val[5:0] = operation_control_reg;
			dma_seq_pkg::OFS_SEQ: rd_val[3:0] = sequence_control_reg;
			dma_seq_pkg::OFS_DEVC: rd_val[2:0] = device_control_reg;
			dma_seq_pkg::OFS_GEN: rd_val[3:0] = general_control_reg;
			dma_seq_pkg::OFS_MPTR: rd_val[23:0] = memory_address_pointer;
			dma_seq_pkg::OFS_DPTR: rd_val[23:0] = device_address_pointer;
			dma_seq_pkg::OFS_CODES: begin
				rd_val[dma_seq_pkg::CODES_MEM_LO +: 3] = memory_space_code;
				rd_val[dma_seq_pkg::CODES_DEV_LO +: 3] = device_space_code;
			end
			dma_seq_pkg::OFS_COUNT: rd_val[15:0] = memory_transfer_counter;
			dma_seq_pkg::OFS_CTRL: begin
				rd_val[dma_seq_pkg::STAT_ACTIVE] = active;
				rd_val[dma_seq_pkg::STAT_DONE] = done_q;
				rd_val[dma_seq_pkg::STAT_ERR] = err_q;
				rd_val[dma_seq_pkg::STAT_CFG] = cfg_err_q;
				rd_val[dma_seq_pkg::STAT_PEND] = req_pend;
				rd_val[dma_seq_pkg::STAT_WIN] = window;
			end
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !hit;
			if (setup && !pwrite) begin
				prdata <= rd_val;
			end
		end
	end

	// set-up registers are frozen while the channel runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operation_control_reg <= 6'h00;
			sequence_control_reg <= 4'h0;
			device_control_reg <= 3'h0;
			general_control_reg <= 4'h0;
			memory_space_code <= 3'h0;
			device_space_code <= 3'h0;
		end else if (wr_en && !active) begin
			case (paddr)
				dma_seq_pkg::OFS_OPER: operation_control_reg <= pwdata[5:0];
				dma_seq_pkg::OFS_SEQ: sequence_control_reg <= pwdata[3:0];
				dma_seq_pkg::OFS_DEVC: device_control_reg <= pwdata[2:0];
				dma_seq_pkg::OFS_GEN: general_control_reg <= pwdata[3:0];
				dma_seq_pkg::OFS_CODES: begin
					memory_space_code <= pwdata[dma_seq_pkg::CODES_MEM_LO +: 3];
					device_space_code <= pwdata[dma_seq_pkg::CODES_DEV_LO +: 3];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memory_address_pointer <= 24'h000000;
		end else if (wr_en && !active && paddr == dma_seq_pkg::OFS_MPTR) begin
			memory_address_pointer <= pwdata[23:0];
		end else if (op_complete) begin
			memory_address_pointer <= mptr_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_address_pointer <= 24'h000000;
		end else if (wr_en && !active && paddr == dma_seq_pkg::OFS_DPTR) begin
			device_address_pointer <= pwdata[23:0];
		end else if (op_complete && !single) begin
			device_address_pointer <= dptr_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memory_transfer_counter <= 16'h0000;
		end else if (wr_en && !active && paddr == dma_seq_pkg::OFS_COUNT) begin
			memory_transfer_counter <= pwdata[15:0];
		end else if (op_complete) begin
			memory_transfer_counter <= count_left;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= dma_seq_pkg::ST_IDLE;
			part_q <= 3'h0;
			pack_q <= 1'b0;
		end else begin
			case (state_q)
				dma_seq_pkg::ST_IDLE: begin
					if (start && !cfg_bad &&
						memory_transfer_counter != 16'h0000) begin
						state_q <= dma_seq_pkg::ST_WAIT;
					end
				end
				dma_seq_pkg::ST_WAIT: begin
					part_q <= 3'h0;
					if (stop_q) begin
						state_q <= dma_seq_pkg::ST_IDLE;
					end else if (req_pend) begin
						pack_q <= pack_d;
						state_q <= single ? dma_seq_pkg::ST_SGL :
							dma_seq_pkg::ST_RD;
					end
				end
				dma_seq_pkg::ST_RD: begin
					if ((bus_req && bus_err) || (stop_q && !bus_req)) begin
						state_q <= dma_seq_pkg::ST_IDLE;
					end else if (bus_req && bus_done) begin
						part_q <= last_rd ? 3'h0 : part_q + 3'h1;
						if (last_rd) begin
							state_q <= dma_seq_pkg::ST_WR;
						end
					end
				end
				dma_seq_pkg::ST_WR, dma_seq_pkg::ST_SGL: begin
					if ((bus_req && bus_err) || (stop_q && !bus_req)) begin
						state_q <= dma_seq_pkg::ST_IDLE;
					end else if (op_complete) begin
						state_q <= count_left == 16'h0000 ?
							dma_seq_pkg::ST_IDLE : dma_seq_pkg::ST_WAIT;
					end else if (bus_req && bus_done) begin
						part_q <= part_q + 3'h1;
					end
				end
				default: state_q <= dma_seq_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_req_q <= 1'b0;
		end else if (start) begin
			first_req_q <= req == dma_seq_pkg::REQ_AUTO;
		end else if (state_q == dma_seq_pkg::ST_WAIT && req_pend) begin
			first_req_q <= 1'b0;
		end
	end

	// a stop waits for the bus cycle in flight to end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_q <= 1'b0;
		end else if (stop_req) begin
			stop_q <= 1'b1;
		end else if (!active) begin
			stop_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
			err_q <= 1'b0;
			cfg_err_q <= 1'b0;
		end else if (start) begin
			done_q <= memory_transfer_counter == 16'h0000 && !cfg_bad;
			err_q <= 1'b0;
			cfg_err_q <= cfg_bad;
		end else begin
			if (op_complete && count_left == 16'h0000) begin
				done_q <= 1'b1;
			end
			if (bus_req && bus_err) begin
				err_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 32'h00000000;
		end else if (bus_req && bus_err) begin
			hold_q <= 32'h00000000;
		end else if (state_q == dma_seq_pkg::ST_WAIT) begin
			hold_q <= 32'h00000000;
		end else if (state_q == dma_seq_pkg::ST_RD && bus_req && bus_done) begin
			hold_q <= cyc_w2 ? {hold_q[15:0], bus_rdata} :
				{hold_q[23:0], bus_rdata[7:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_req <= 1'b0;
			bus_addr <= 24'h000000;
			bus_fc <= 3'h0;
			bus_rw <= 1'b1;
			bus_word <= 1'b0;
			bus_wdata <= 16'h0000;
			ack_n <= 1'b1;
		end else if (bus_req) begin
			if (cyc_end) begin
				bus_req <= 1'b0;
				ack_n <= 1'b1;
			end
		end else if ((state_q == dma_seq_pkg::ST_RD ||
			state_q == dma_seq_pkg::ST_WR ||
			state_q == dma_seq_pkg::ST_SGL) && !stop_q) begin
			bus_req <= 1'b1;
			bus_addr <= cyc_addr;
			bus_fc <= cyc_mem ? memory_space_code : device_space_code;
			bus_rw <= single ? dir_m2d :
				state_q == dma_seq_pkg::ST_RD;
			bus_word <= cyc_w2;
			bus_wdata <= cyc_wdata;
			ack_n <= !cyc_ack;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_cnt_q <= 3'h0;
		end else if (state_q == dma_seq_pkg::ST_WAIT) begin
			cyc_cnt_q <= 3'h0;
		end else if (bus_req && bus_done) begin
			cyc_cnt_q <= cyc_cnt_q + 3'h1;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_err;
		bus_req && bus_err;
	endsequence
	sequence s_start_max;
		state_q == dma_seq_pkg::ST_WAIT && req == dma_seq_pkg::REQ_MAX &&
			memory_transfer_counter != 16'h0000 && !stop_q;
	endsequence

	single_rw_a: assert property (state_q == dma_seq_pkg::ST_SGL &&
		bus_req |-> bus_rw == dir_m2d && bus_addr == memory_address_pointer)
		else $error("single-address direction or address wrong");
	dual_src_a: assert property (state_q == dma_seq_pkg::ST_RD && bus_req
		|-> bus_fc == (dir_m2d ? memory_space_code : device_space_code))
		else $error("read cycle uses wrong space code");
	single_step_a: assert property (op_complete && single &&
		memory_pointer_count_mode == dma_seq_pkg::CNT_INC |=>
		memory_address_pointer == $past(memory_address_pointer) +
		(size == dma_seq_pkg::SZ_WORD ? 24'h000002 : 24'h000001))
		else $error("single-address pointer step wrong");
	dual_cycles_a: assert property (op_complete && !single |->
		cyc_cnt_q >= 3'h1 && cyc_cnt_q <= 3'h5)
		else $error("operand cycle count outside two to six");
	err_noupd_a: assert property (s_err |=>
		$stable(memory_address_pointer) && $stable(device_address_pointer)
		&& $stable(memory_transfer_counter) && !active)
		else $error("aborted operand updated a register");
	err_discard_a: assert property (s_err |=> hold_q == 32'h00000000)
		else $error("held data kept after bus error");
	count_hold_a: assert property (active && !op_complete |=>
		$stable(memory_transfer_counter))
		else $error("counter moved before operand completed");
	ack_quiet_a: assert property (internal && !single |-> ack_n)
		else $error("acknowledge asserted on internal request");
	max_req_a: assert property (s_start_max |=>
		state_q == dma_seq_pkg::ST_RD || state_q == dma_seq_pkg::ST_SGL)
		else $error("maximum-rate request not taken at once");
	auto_first_a: assert property (start && req == dma_seq_pkg::REQ_AUTO &&
		!cfg_bad && memory_transfer_counter != 16'h0000 ##1 !stop_q
		|=> state_q != dma_seq_pkg::ST_WAIT)
		else $error("auto-start first request not internal");
endmodule

// file: sim/bus_mem_model.sv
`timescale 1ns/1ps
module bus_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_req,
	input wire logic bus_rw,
	input wire logic [23:0] bus_addr,
	input wire logic [3:0] lat,
	input wire logic err_on,
	output logic [15:0] bus_rdata,
	output logic bus_done,
	output logic bus_err
);
	logic [3:0] cnt_q;
	logic end_q;
	logic hit;
	assign hit = bus_req && !end_q && cnt_q == lat;
	// one answer per request; end_q blocks a second one while req lingers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			end_q <= 1'b0;
			bus_done <= 1'b0;
			bus_err <= 1'b0;
			bus_rdata <= 16'h0000;
		end else begin
			cnt_q <= bus_req ? cnt_q + 4'h1 : 4'h0;
			end_q <= bus_req && (end_q || hit);
			bus_done <= hit && !err_on;
			bus_err <= hit && err_on;
			// data only valid with the answer, churns otherwise
			if (hit && bus_rw) begin
				bus_rdata <= {bus_addr[7:0], ~bus_addr[7:0]};
			end else begin
				bus_rdata <= ~bus_rdata;
			end
		end
	end
endmodule

// file: sim/dma_channel_transfer_sequencer_test.sv
`timescale 1ns/1ps
module dma_channel_transfer_sequencer_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, bus_req, bus_rw, bus_word, bus_done, bus_err;
	logic ack_n, err_on = 0;
	logic [23:0] bus_addr;
	logic [2:0] bus_fc;
	logic [15:0] bus_wdata, bus_rdata;
	logic [3:0] lat = 4'h0;
	logic [23:0] qa[$];
	logic qr[$];
	logic [15:0] qw[$];
	int n_errors = 0, cmp_count = 0, ack_lo = 0;
	dma_channel_transfer_sequencer dma_channel_transfer_sequencer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_req(bus_req),
		.bus_addr(bus_addr), .bus_fc(bus_fc), .bus_rw(bus_rw),
		.bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_done(bus_done), .bus_err(bus_err), .ack_n(ack_n),
		.bgack_n(!bus_req), .ext_req_n(1'b1));
	bus_mem_model bus_mem_model_i (.pclk(pclk), .presetn(presetn),
		.bus_req(bus_req), .bus_rw(bus_rw), .bus_addr(bus_addr), .lat(lat),
		.err_on(err_on), .bus_rdata(bus_rdata), .bus_done(bus_done),
		.bus_err(bus_err));
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (bus_req && bus_done) begin
			qa.push_back(bus_addr);
			qr.push_back(bus_rw);
			qw.push_back(bus_wdata);
		end
		if (bus_req && !ack_n) begin
			ack_lo++;
		end
	end
	task wrap_up;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				n_errors++;
				wrap_up();
			end
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// program, start, then poll until the channel drops active
	task run(input logic [31:0] op, sq, dv, mp, dp, ct);
		int n;
		apb(1, 8'h00, op);
		apb(1, 8'h04, sq);
		apb(1, 8'h08, dv);
		apb(1, 8'h10, mp);
		apb(1, 8'h14, dp);
		apb(1, 8'h1C, ct);
		qa = {};
		qr = {};
		qw = {};
		ack_lo = 0;
		apb(1, 8'h20, 32'h1);
		n = 0;
		r = 32'h1;
		while (r[0] !== 1'b0) begin
			n++;
			if (n > 200) begin
				n_errors++;
				wrap_up();
			end
			apb(0, 8'h20, 32'h0);
		end
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h20, 32'h0);
		chk(r, 32'h0);
		apb(0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		// dual word mem to dev, mem up, dev down, two operands
		run(32'h3, 32'h9, 32'h1, 32'h100, 32'h200, 32'h2);
		chk(qa.size(), 32'h4);
		chk({qa[0], 7'h0, qr[0]}, 32'h10001);
		chk({qa[1], 7'h0, qr[1]}, 32'h20000);
		chk(qw[1], 32'h00FF);
		chk({qa[2], 7'h0, qr[2]}, 32'h10201);
		chk({qa[3], 8'h00}, 32'h1FE00);
		chk(qw[3], 32'h02FD);
		chk(ack_lo, 32'h0);
		apb(0, 8'h10, 32'h0);
		chk(r, 32'h104);
		apb(0, 8'h14, 32'h0);
		chk(r, 32'h1FC);
		apb(0, 8'h1C, 32'h0);
		chk(r, 32'h0);
		// single byte both directions, slow answers
		lat <= 4'h3;
		for (int d = 0; d < 2; d++) begin
			run(32'h20 | d, 32'h1, 32'h0, 32'h300, 32'h0, 32'h2);
			chk(qa.size(), 32'h2);
			chk({qa[1], 7'h0, qr[1]}, {24'h301, 7'h0, d[0]});
			apb(0, 8'h10, 32'h0);
			chk(r, 32'h302);
		end
		// bus error leaves pointers and count, restart retries read
		lat <= 4'h1;
		err_on <= 1;
		run(32'h3, 32'h5, 32'h1, 32'h100, 32'h200, 32'h1);
		chk({29'h0, r[2:0]} & 32'h4, 32'h4);
		apb(0, 8'h10, 32'h0);
		chk(r, 32'h100);
		apb(0, 8'h1C, 32'h0);
		chk(r, 32'h1);
		err_on <= 0;
		run(32'h3, 32'h5, 32'h1, 32'h100, 32'h200, 32'h1);
		chk({qa[0], 7'h0, qr[0]}, 32'h10001);
		chk(qw[1], 32'h00FF);
		apb(0, 8'h1C, 32'h0);
		chk(r, 32'h0);
		// byte pairs packed into word cycles
		run(32'h1, 32'h5, 32'h1, 32'h100, 32'h200, 32'h2);
		chk(qa.size(), 32'h2);
		apb(0, 8'h10, 32'h0);
		chk(r, 32'h102);
		// word to 8-bit device, fixed pointers
		run(32'h3, 32'h0, 32'h0, 32'h100, 32'h200, 32'h1);
		chk(qa.size(), 32'h3);
		chk({qa[2], qw[2][7:0]}, 32'h202FF);
		apb(0, 8'h14, 32'h0);
		chk(r, 32'h200);
		// limited rate still finishes the block
		run(32'h0B, 32'h5, 32'h1, 32'h100, 32'h200, 32'h2);
		chk(qa.size(), 32'h4);
		wrap_up();
	end
endmodule
